// ### src/stc_core.sv
// Standard timer core with compare-A, compare-P, pin control and Avalon-MM registers.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module stc_core
    import stc_pkg::*;
#(
    parameter int CNT_W = STC_WIDE_W,
    parameter int P_W = (CNT_W == STC_NARROW_W) ? STC_NARROW_P_W : STC_WIDE_P_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic timer_tick,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic timer_output_pin,
    output logic timer_output_pin_oe_n,
    output logic compare_a_match_flag,
    output logic compare_p_match_flag
);

    localparam bit NARROW = (CNT_W == STC_NARROW_W);
    localparam int LOW_W = CNT_W - P_W;

    stc_ctrl0_t ctrl0_q;
    stc_ctrl1_t ctrl1_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cmpa_q;
    logic [P_W-1:0] cmpp_q;
    logic [1:0] flags_q;
    logic run_prev_q;
    logic level_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic pin_q;
    logic oe_n_q;

    logic req;
    logic wr_stb;
    logic [7:0] wbyte;
    logic [1:0] mode;
    logic [1:0] iofn;
    logic is_cmp;
    logic is_tmr;
    logic is_cap;
    logic is_pwm;
    logic is_spo;
    logic run_rise;
    logic count_en;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] p_full;
    logic a_hit;
    logic p_hit;
    logic clr_on_a;
    logic clr_on_p;
    logic set_a;
    logic set_p;
    logic [CNT_W-1:0] duty;
    logic pwm_on;
    logic driven;
    logic pin_d;
    logic [7:0] rmux;

    // Mode decode.
    assign mode = {ctrl1_q.mode_field_hi, ctrl1_q.mode_field_lo};
    assign iofn = {ctrl1_q.pin_function_hi, ctrl1_q.pin_function_lo};
    assign is_cmp = (mode == STC_MODE_CMP);
    assign is_tmr = (mode == STC_MODE_TMR);
    assign is_cap = (mode == STC_MODE_CAP);
    assign is_spo = (mode == STC_MODE_PWM) && (iofn == STC_IO_PULSE);
    assign is_pwm = (mode == STC_MODE_PWM) && (iofn != STC_IO_PULSE);

    // Counting and comparison.
    assign run_rise = ctrl0_q.counter_run && !run_prev_q;
    assign count_en = ctrl0_q.counter_run && !ctrl0_q.pause && timer_tick;
    assign cnt_nxt = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    assign p_full = {cmpp_q, {LOW_W{1'b0}}};
    // A zero compare-A never matches, so the counter simply wraps at its maximum.
    assign a_hit = count_en && (cmpa_q != '0) && (cnt_nxt == cmpa_q);
    // With P zero the wrap to zero stands in for the P match.
    assign p_hit = count_en && ((cmpp_q != '0) ? (cnt_nxt == p_full) : (cnt_nxt == '0));

    always_comb begin
        clr_on_a = 1'b0;
        clr_on_p = 1'b0;
        if (is_cmp || is_tmr) begin
            clr_on_a = ctrl1_q.clear_source_sel;
            clr_on_p = !ctrl1_q.clear_source_sel;
        end else if (is_pwm) begin
            clr_on_a = ctrl1_q.duty_period_swap;
            clr_on_p = !ctrl1_q.duty_period_swap;
        end else if (is_cap) begin
            clr_on_p = 1'b1;
        end
    end

    assign set_a = a_hit && !is_cap;
    assign set_p = p_hit && !is_spo && !((is_cmp || is_tmr) && ctrl1_q.clear_source_sel);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (run_rise) begin
            cnt_q <= '0;
        end else if (count_en) begin
            if ((clr_on_a && a_hit) || (clr_on_p && p_hit)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_nxt;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl0_q.counter_run;
        end
    end

    // Hardware sets win over a software clear in the same cycle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flags_q <= 2'h0;
        end else begin
            if (set_a) begin
                flags_q[STC_FLAG_A] <= 1'b1;
            end else if (wr_stb && avs_address == STC_OFF_FLAGS && wbyte[STC_FLAG_A]) begin
                flags_q[STC_FLAG_A] <= 1'b0;
            end
            if (set_p) begin
                flags_q[STC_FLAG_P] <= 1'b1;
            end else if (wr_stb && avs_address == STC_OFF_FLAGS && wbyte[STC_FLAG_P]) begin
                flags_q[STC_FLAG_P] <= 1'b0;
            end
        end
    end

    assign compare_a_match_flag = flags_q[STC_FLAG_A];
    assign compare_p_match_flag = flags_q[STC_FLAG_P];

    // Compare-mode pin level, loaded on a run-bit rising edge, otherwise moved only by compare-A events.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            level_q <= 1'b0;
        end else if (run_rise) begin
            level_q <= ctrl1_q.output_initial_level_sel;
        end else if (is_cmp && set_a) begin
            case (iofn)
                STC_IO_LOW: begin
                    level_q <= 1'b0;
                end
                STC_IO_HIGH: begin
                    level_q <= 1'b1;
                end
                STC_IO_TOGGLE: begin
                    level_q <= !level_q;
                end
                default: begin
                    level_q <= level_q;
                end
            endcase
        end
    end

    // PWM: duty beyond the period gives a steady active level.
    assign duty = ctrl1_q.duty_period_swap ? p_full : cmpa_q;
    assign pwm_on = (ctrl1_q.duty_period_swap && cmpp_q == '0) || (cnt_q < duty);
    assign driven = is_cmp || is_pwm || is_spo;

    always_comb begin
        pin_d = 1'b0;
        if (is_cmp) begin
            pin_d = level_q;
        end else if (is_pwm) begin
            case (iofn)
                STC_IO_PWM_OFF: begin
                    pin_d = !ctrl1_q.output_initial_level_sel;
                end
                STC_IO_PWM_ON: begin
                    pin_d = ctrl1_q.output_initial_level_sel;
                end
                default: begin
                    pin_d = pwm_on ? ctrl1_q.output_initial_level_sel
                                   : !ctrl1_q.output_initial_level_sel;
                end
            endcase
        end else if (is_spo) begin
            pin_d = ctrl0_q.counter_run ? ctrl1_q.output_initial_level_sel
                                        : !ctrl1_q.output_initial_level_sel;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            pin_q <= driven && (pin_d ^ ctrl1_q.output_invert);
            oe_n_q <= !driven;
        end
    end

    assign timer_output_pin = pin_q;
    assign timer_output_pin_oe_n = oe_n_q;

    // Bus slave: one wait cycle, then the access completes.
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign wr_stb = avs_write && ack_q && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_comb begin
        rmux = 8'h00;
        if (avs_address == STC_OFF_CTRL0) begin
            rmux = ctrl0_q;
            // The wide instance has no period bits here, so only bits 2:0 read as zero.
            if (!NARROW) begin
                rmux[STC_NARROW_P_W-1:0] = '0;
            end
        end else if (avs_address == STC_OFF_CTRL1) begin
            rmux = ctrl1_q;
        end else if (avs_address == STC_OFF_CNT_LO) begin
            rmux = cnt_q[7:0];
        end else if (avs_address == STC_OFF_CNT_HI) begin
            rmux = 8'(cnt_q >> STC_BYTE_W);
        end else if (avs_address == STC_OFF_CMPA_LO) begin
            rmux = cmpa_q[7:0];
        end else if (avs_address == STC_OFF_CMPA_HI) begin
            rmux = 8'(cmpa_q >> STC_BYTE_W);
        end else if (avs_address == STC_OFF_CMPP) begin
            rmux = NARROW ? 8'h00 : 8'(cmpp_q);
        end else if (avs_address == STC_OFF_FLAGS) begin
            rmux = {6'h00, flags_q};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rmux;
        end
    end

    assign avs_readdata = {24'h000000, rdata_q};

    // Control registers; a single-pulse compare-A match stops the run bit.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q <= STC_CTRL0_RST;
        end else if (wr_stb && avs_address == STC_OFF_CTRL0) begin
            ctrl0_q <= wbyte;
        end else if (is_spo && a_hit) begin
            ctrl0_q.counter_run <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl1_q <= STC_CTRL1_RST;
        end else if (wr_stb && avs_address == STC_OFF_CTRL1) begin
            ctrl1_q <= wbyte;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmpa_q <= '0;
        end else if (wr_stb && avs_address == STC_OFF_CMPA_LO) begin
            cmpa_q[7:0] <= wbyte;
        end else if (wr_stb && avs_address == STC_OFF_CMPA_HI) begin
            cmpa_q[CNT_W-1:STC_BYTE_W] <= wbyte[CNT_W-STC_BYTE_W-1:0];
        end
    end

    // The narrow instance keeps its period bits in the low bits of control zero.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmpp_q <= '0;
        end else if (NARROW && wr_stb && avs_address == STC_OFF_CTRL0) begin
            cmpp_q <= wbyte[P_W-1:0];
        end else if (!NARROW && wr_stb && avs_address == STC_OFF_CMPP) begin
            cmpp_q <= wbyte[P_W-1:0];
        end
    end

endmodule

// ### pkg/stc_pkg.sv
// Constants, field layouts and types of the standard timer compare core.
// Contract
// - Compare mode: initial-level bit sets the pin before any compare-A match.
// - PWM mode: initial-level bit gives the waveform's active level.
// - Single-pulse mode: run-bit rising edge drives the pin to the initial level.
// - Invert bit flips the pin; invert and initial level ignored in timer mode.
// - Swap bit 0: P sets period, A duty; 1 exchanges them.
// - Clear select 1 clears on A match; 0 on P match or overflow.
// - Overflow clearing only when the P value is all zero.
// - Clear select ignored in PWM, single-pulse and capture modes.
// - Counter readable, not writable, as low and high byte.
// - Narrow instance: high byte bits 7 to 2 of count and A read zero.
// - Compare-A value read/write as two bytes, reset to zero.
// - Wide instance: 8-bit P compares counter bits 15:8, zero means 65536.
// - Mode field 00 selects compare-match output mode; five modes total.
// - Compare mode, clear select 0: both A and P flags raised.
// - Clear select 1: only the A flag, never the P flag.
// - A all zero: counter overflows at maximum, no A flag.
// - Compare mode pin changes only on A-flag events, never on P.
// - A match drives pin high, low or toggle by pin function; zero holds.
// - Run-bit rising edge returns the pin to its initial level.
// - Mode 11 is timer mode: same flags, pin not driven.
// - Pin function codes: 00 hold, 01 low, 10 high, 11 toggle.
// - Run rising edge zeroes counter; falling edge stops and holds it.
package stc_pkg;

    localparam int STC_NARROW_W = 10;
    localparam int STC_WIDE_W = 16;
    localparam int STC_NARROW_P_W = 3;
    localparam int STC_WIDE_P_W = 8;
    localparam int STC_BYTE_W = 8;

    localparam logic [4:0] STC_OFF_CTRL0 = 5'h00;
    localparam logic [4:0] STC_OFF_CTRL1 = 5'h04;
    localparam logic [4:0] STC_OFF_CNT_LO = 5'h08;
    localparam logic [4:0] STC_OFF_CNT_HI = 5'h0c;
    localparam logic [4:0] STC_OFF_CMPA_LO = 5'h10;
    localparam logic [4:0] STC_OFF_CMPA_HI = 5'h14;
    localparam logic [4:0] STC_OFF_CMPP = 5'h18;
    localparam logic [4:0] STC_OFF_FLAGS = 5'h1c;

    localparam logic [1:0] STC_MODE_CMP = 2'h0;
    localparam logic [1:0] STC_MODE_CAP = 2'h1;
    localparam logic [1:0] STC_MODE_PWM = 2'h2;
    localparam logic [1:0] STC_MODE_TMR = 2'h3;

    localparam logic [1:0] STC_IO_HOLD = 2'h0;
    localparam logic [1:0] STC_IO_LOW = 2'h1;
    localparam logic [1:0] STC_IO_HIGH = 2'h2;
    localparam logic [1:0] STC_IO_TOGGLE = 2'h3;
    localparam logic [1:0] STC_IO_PWM_OFF = 2'h0;
    localparam logic [1:0] STC_IO_PWM_ON = 2'h1;
    localparam logic [1:0] STC_IO_PWM_WAVE = 2'h2;
    localparam logic [1:0] STC_IO_PULSE = 2'h3;

    localparam int STC_FLAG_A = 0;
    localparam int STC_FLAG_P = 1;

    typedef struct packed {
        logic pause;
        logic [2:0] clk_sel;
        logic counter_run;
        logic [2:0] period_narrow;
    } stc_ctrl0_t;

    typedef struct packed {
        logic mode_field_hi;
        logic mode_field_lo;
        logic pin_function_hi;
        logic pin_function_lo;
        logic output_initial_level_sel;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_sel;
    } stc_ctrl1_t;

    localparam stc_ctrl0_t STC_CTRL0_RST = 8'h00;
    localparam stc_ctrl1_t STC_CTRL1_RST = 8'h00;
    localparam logic [7:0] STC_BYTE_RST = 8'h00;

endpackage

// ### tb/stc_pin_load.sv
// External load on the timer output pin, with a pull-down on the line.
`timescale 1ns/1ns
module stc_pin_load (
    input logic pin,
    input logic pin_oe_n,
    output logic level
);
    // Once the core lets go, the pull-down wins, so a released pin never shows its last value.
    assign level = pin_oe_n ? 1'b0 : pin;
endmodule

// ### tb/stc_core_monitor.sv
// Port checker for the standard timer compare core.
`timescale 1ns/1ns
module stc_core_monitor (
    input logic clk_sys,
    input logic nrst,
    input logic timer_tick,
    input logic [4:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic timer_output_pin,
    input logic timer_output_pin_oe_n,
    input logic compare_a_match_flag,
    input logic compare_p_match_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic flag_wr;
    logic [1:0] flags;
    assign flag_wr = avs_write && !avs_waitrequest && avs_address == 5'h1c;
    assign flags = {compare_p_match_flag, compare_a_match_flag};
    sequence s_stall;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    a_one_wait: assert property (s_stall |=> !avs_waitrequest)
        else $error("bus access took more than one wait state");
    a_hi_zero: assert property (avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rdata_held: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data changed without a read");
    a_aflag_tick: assert property ($rose(compare_a_match_flag) |-> $past(timer_tick))
        else $error("compare A flag set without a count");
    a_pflag_tick: assert property ($rose(compare_p_match_flag) |-> $past(timer_tick))
        else $error("compare P flag set without a count");
    a_flag_clear: assert property (|($past(flags) & ~flags) |-> $past(flag_wr))
        else $error("flag cleared without a flag write");
    a_pin_cause: assert property ($changed(timer_output_pin) |->
        $past(timer_tick) || $past(timer_tick, 2) || $past(timer_tick, 3) ||
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("pin moved without a count or a register write");
    a_idle_low: assert property (timer_output_pin_oe_n |-> !timer_output_pin)
        else $error("released pin not low");
endmodule
bind stc_core stc_core_monitor u_mon (.*);

// ### tb/test_standard_timer_compare_core.sv
// Self-checking bench for the standard timer compare core.
`timescale 1ns/1ns
module test_standard_timer_compare_core
    import stc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic timer_tick = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, pin, oe_n, flag_a, flag_p, level;
    logic [7:0] rd_q;
    logic [31:0] avs_readdata_n;
    logic [7:0] rdn_q;
    int err_total = 0;
    int n_checks = 0;
    stc_core #(.CNT_W(STC_WIDE_W)) dut (.clk_sys(clk_sys), .nrst(nrst), .timer_tick(timer_tick),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_output_pin(pin), .timer_output_pin_oe_n(oe_n),
        .compare_a_match_flag(flag_a), .compare_p_match_flag(flag_p));
    // The narrow core shares the bus and answers with the same timing.
    stc_core #(.CNT_W(STC_NARROW_W)) u_narrow (.clk_sys(clk_sys), .nrst(nrst),
        .timer_tick(timer_tick), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata_n), .avs_waitrequest(), .timer_output_pin(),
        .timer_output_pin_oe_n(), .compare_a_match_flag(), .compare_p_match_flag());
    stc_pin_load u_load (.pin(pin), .pin_oe_n(oe_n), .level(level));
    initial forever #25 clk_sys = ~clk_sys;
    task final_report;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task xfer(input logic [4:0] a, input logic wr, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd_q = avs_readdata[7:0];
        rdn_q = avs_readdata_n[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(rd_q, e);
    endtask
    task pchk(input logic e);
        chk({7'h0, level}, {7'h0, e});
    endtask
    // Three idle cycles let the registered pin settle before it is looked at.
    task tk(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            timer_tick <= 1'b1;
            @(posedge clk_sys);
            timer_tick <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task start(input logic [7:0] c1);
        wr(5'h00, 8'h00);
        wr(5'h04, c1);
        wr(5'h1c, 8'h03);
        wr(5'h00, 8'h08);
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        final_report;
    end
    initial begin
        logic [1:0] io;
        logic oc, pol;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 0; a < 32; a += 4) rd(5'(a), 8'h00);
        rd(5'h02, 8'h00);
        wr(5'h08, 8'hff);
        rd(5'h08, 8'h00);
        avs_byteenable <= 4'h0;
        wr(5'h10, 8'h55);
        avs_byteenable <= 4'h1;
        rd(5'h10, 8'h00);
        wr(5'h14, 8'haa);
        rd(5'h14, 8'haa);
        chk(rdn_q, 8'h02);
        $display("bus test done");
        wr(5'h10, 8'h03);
        wr(5'h14, 8'h00);
        for (int i = 0; i < 8; i++) begin
            io = 2'(i);
            pol = i[2];
            oc = ~io[1];
            start({2'b00, io, oc, pol, 2'b00});
            pchk(oc ^ pol);
            tk(3);
            pchk((io == 2'h0 ? oc : io == 2'h1 ? 1'b0 : io == 2'h2 ? 1'b1 : ~oc) ^ pol);
            rd(5'h08, 8'h03);
            rd(5'h1c, 8'h01);
        end
        $display("compare pin test done");
        wr(5'h10, 8'h80);
        wr(5'h14, 8'h01);
        wr(5'h18, 8'h01);
        start(8'h01);
        tk(400);
        rd(5'h1c, 8'h01);
        rd(5'h0c, 8'h00);
        wr(5'h14, 8'h00);
        wr(5'h10, 8'h10);
        start(8'h00);
        tk(300);
        rd(5'h1c, 8'h03);
        chk({6'h00, flag_p, flag_a}, 8'h03);
        rd(5'h0c, 8'h00);
        $display("clear source test done");
        start(8'hcc);
        wr(5'h10, 8'h00);
        pchk(1'b0);
        chk({7'h0, oe_n}, 8'h01);
        tk(5);
        rd(5'h1c, 8'h00);
        rd(5'h08, 8'h05);
        wr(5'h00, 8'h00);
        wr(5'h00, 8'h88);
        rd(5'h00, 8'h88);
        tk(3);
        rd(5'h08, 8'h00);
        wr(5'h00, 8'h08);
        tk(2);
        rd(5'h08, 8'h02);
        wr(5'h00, 8'h00);
        tk(3);
        rd(5'h08, 8'h02);
        $display("timer mode test done");
        wr(5'h10, 8'h10);
        for (int i = 0; i < 4; i++) begin
            start({4'b1010, i[0], 1'b0, i[1], ~i[1]});
            tk(20);
            pchk(i[1] ? i[0] : ~i[0]);
        end
        start(8'hb8);
        pchk(1'b1);
        tk(16);
        pchk(1'b0);
        rd(5'h00, 8'h00);
        start(8'h4d);
        tk(16);
        pchk(1'b0);
        chk({7'h0, oe_n}, 8'h01);
        rd(5'h08, 8'h10);
        rd(5'h1c, 8'h00);
        $display("pwm test done");
        final_report;
    end
endmodule
